// *** verilog/bsc_pkg.sv ***
// Constants, register layout and command helpers for the bridge
// system-error cause flags and port option register.
// Assumes one PCI clock domain and configuration accesses by dword offset.
`default_nettype none

package bsc_pkg;

  //////////////////////////////////////////////////////////////////////////
  // Register offsets (byte address of the configuration dword)
  localparam logic [7:0]  SERR_STATUS_OFS = 8'h68; // Cause flags
  localparam logic [7:0]  PORT_OPT_OFS    = 8'h74; // Port options

  //////////////////////////////////////////////////////////////////////////
  // Cause flag field: bits 23:16, all in byte lane 2
  localparam int          STAT_LSB   = 16;         // Field low bit
  localparam int          STAT_W     = 8;          // Number of causes
  localparam int          STAT_LANE  = 2;          // Byte enable lane
  localparam logic [7:0]  STAT_RESET = 8'h00;      // All clear at reset

  // Cause index inside the field (bit = STAT_LSB + index)
  localparam int CAUSE_ADDR_PAR  = 0; // Address parity, either bus
  localparam int CAUSE_PW_PAR    = 1; // Posted write data parity
  localparam int CAUSE_PW_RETRY  = 2; // Posted write retry limit
  localparam int CAUSE_PW_TABORT = 3; // Target abort on posted write
  localparam int CAUSE_PW_MABORT = 4; // Master abort on posted write
  localparam int CAUSE_DW_RETRY  = 5; // Delayed write retry limit
  localparam int CAUSE_DR_NODATA = 6; // Delayed read got no data
  localparam int CAUSE_DT_TMO    = 7; // Delayed transaction timeout

  //////////////////////////////////////////////////////////////////////////
  // Port option field: 16 bits in lanes 0 and 1
  localparam int          OPT_W            = 16;
  localparam int          OPT_PRI_RD_ALIAS = 1;  // Primary read alias
  localparam int          OPT_PRI_WR_ALIAS = 2;  // Primary write alias
  localparam int          OPT_SEC_RD_ALIAS = 3;  // Secondary read alias
  localparam int          OPT_SEC_WR_ALIAS = 4;  // Secondary write alias
  localparam int          OPT_LONG_LOCK    = 9;  // Long request on lock
  localparam int          OPT_SEC_HOLD     = 10; // Secondary holds request
  localparam int          OPT_PRI_HOLD     = 11; // Primary holds request
  localparam logic [15:0] OPT_WMASK        = 16'h0E1E; // Writable bits
  localparam logic [15:0] OPT_RESET        = 16'h0C00; // Hold bits set

  //////////////////////////////////////////////////////////////////////////
  // Bus command codes used by retry matching
  localparam logic [3:0] CMD_MEM_RD      = 4'h6; // Memory read
  localparam logic [3:0] CMD_MEM_WR      = 4'h7; // Memory write
  localparam logic [3:0] CMD_MEM_RD_MULT = 4'hC; // Read multiple
  localparam logic [3:0] CMD_MEM_RD_LINE = 4'hE; // Read line
  localparam logic [3:0] CMD_MEM_WR_INV  = 4'hF; // Write and invalidate

  // Folds an aliased command onto its base command when enabled
  function automatic logic [3:0] norm_cmd(input logic [3:0] cmd,
                                          input logic       rd_alias,
                                          input logic       wr_alias);
    logic [3:0] res;
    res = cmd;
    if (rd_alias && (cmd == CMD_MEM_RD_MULT || cmd == CMD_MEM_RD_LINE)) begin
      res = CMD_MEM_RD;
    end
    if (wr_alias && cmd == CMD_MEM_WR_INV) begin
      res = CMD_MEM_WR;
    end
    return res;
  endfunction : norm_cmd

endpackage : bsc_pkg

`default_nettype wire

// *** verilog/bsc_match_if.sv ***
// Interface between the register block and one retry command matcher.
// Assumes the owner drives commands and alias enables on the PCI clock.
`timescale 1ns/10ps
`default_nettype none

interface bsc_match_if;
  logic [3:0] queued_cmd; // Command of the queued delayed transaction
  logic [3:0] retry_cmd;  // Command of the repeated transaction
  logic       rd_alias;   // Read command aliasing enabled
  logic       wr_alias;   // Write command aliasing enabled
  logic       match;      // Registered match result

  modport matcher (input queued_cmd, retry_cmd, rd_alias, wr_alias,
                   output match);
  modport owner   (output queued_cmd, retry_cmd, rd_alias, wr_alias,
                   input match);
endinterface : bsc_match_if

`default_nettype wire

// *** verilog/bsc_cmd_match.sv ***
// Retry command matcher for one port of the bridge.
// Assumes commands are stable in the cycle they are presented; the
// answer appears one clock later.
`timescale 1ns/10ps
`default_nettype none

module bsc_cmd_match (
  input  wire logic     clk, // PCI clock
  input  wire logic     rst, // Synchronous reset, active high
  bsc_match_if.matcher  m    // Commands in, match out
);

  ////////////////////////////////////////////////////////////////////////////
  // State
  typedef struct packed {
    logic match; // Registered comparison
  } bsc_match_state_t;

  bsc_match_state_t q;      // Current state
  bsc_match_state_t next_q; // Next state

  // Both sides folded the same way, so exact match falls out when off
  always_comb begin
    next_q       = q;
    next_q.match = bsc_pkg::norm_cmd(m.queued_cmd, m.rd_alias, m.wr_alias) ==
                   bsc_pkg::norm_cmd(m.retry_cmd, m.rd_alias, m.wr_alias);
  end

  // Register the state
  always_ff @(posedge clk) begin
    if (rst) begin
      q <= '0;
    end else begin
      q <= next_q;
    end
  end

  assign m.match = q.match;

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  a_read_alias_on: assert property (
    m.rd_alias && m.queued_cmd == bsc_pkg::CMD_MEM_RD &&
    (m.retry_cmd == bsc_pkg::CMD_MEM_RD_LINE ||
     m.retry_cmd == bsc_pkg::CMD_MEM_RD_MULT) |=> m.match)
    else $error("aliased read retry not matched");

  a_read_exact: assert property (
    !m.rd_alias && m.queued_cmd == bsc_pkg::CMD_MEM_RD &&
    m.retry_cmd == bsc_pkg::CMD_MEM_RD_MULT |=> !m.match)
    else $error("read matched while alias off");

  a_write_alias: assert property (
    m.queued_cmd == bsc_pkg::CMD_MEM_WR &&
    m.retry_cmd == bsc_pkg::CMD_MEM_WR_INV |=> m.match == $past(m.wr_alias))
    else $error("write alias result wrong");

endmodule : bsc_cmd_match

`default_nettype wire

// *** verilog/bsc_regs.sv ***
// Bridge system-error cause flags and port option register, with the
// request hold logic of the internal primary and secondary masters.
// Assumes all inputs are synchronous to the PCI clock and that
// configuration reads and writes are single-cycle strobes.
//
// Function
// - Flag address parity error system-error assertion
// - Flag posted write data parity error
// - Flag posted write retry limit exhausted
// - Flag target abort on posted write
// - Flag master abort on posted write
// - Flag delayed write retry limit exhausted
// - Flag delayed read with no data
// - Flag delayed transaction master timeout
// - Primary read retries alias to memory read
// - Primary write-invalidate aliases to memory write
// - Secondary read retries alias to memory read
// - Secondary write-invalidate aliases to memory write
// - Option enables long request on lock
// - Secondary master hold request option, default set
// - Primary master hold request option, default set
// - Reserved option bits read zero, unwritable
// - Per-cause disable suppresses system-error output
`timescale 1ns/10ps
`default_nettype none

module bsc_regs (
  input  wire logic        clk,              // PCI clock
  input  wire logic        rst,              // Synchronous reset, high
  // Configuration access
  input  wire logic        cfg_rd,           // Read strobe
  input  wire logic        cfg_wr,           // Write strobe
  input  wire logic [7:0]  cfg_addr,         // Dword byte address
  input  wire logic [3:0]  cfg_be,           // Byte enables
  input  wire logic [31:0] cfg_wdata,        // Write data
  output var  logic [31:0] cfg_rdata,        // Read data, registered
  // System-error causes
  input  wire logic        serr_enable,      // Command register enable
  input  wire logic [7:0]  serr_disable,     // Per-cause disable mask
  input  wire logic [7:0]  serr_event,       // Cause pulses
  output var  logic        primary_system_error_out_n, // Low one cycle
  // Retry command matching
  input  wire logic [3:0]  pri_queued_cmd,   // Primary queued command
  input  wire logic [3:0]  pri_retry_cmd,    // Primary retried command
  output var  logic        pri_cmd_match,    // Primary match
  input  wire logic [3:0]  sec_queued_cmd,   // Secondary queued command
  input  wire logic [3:0]  sec_retry_cmd,    // Secondary retried command
  output var  logic        sec_cmd_match,    // Secondary match
  // Primary internal master
  input  wire logic        pri_pending,      // FIFO has transactions
  input  wire logic        pri_frame,        // Master drives FRAME_L
  input  wire logic        pri_target_term,  // Target terminated
  input  wire logic        pri_lock,         // Lock cycle in progress
  output var  logic        pri_req_n,        // REQ_L of primary master
  // Secondary internal master
  input  wire logic        sec_pending,      // FIFO has transactions
  input  wire logic        sec_frame,        // Master drives FRAME_L
  input  wire logic        sec_target_term,  // Target terminated
  input  wire logic        sec_lock,         // Lock cycle in progress
  output var  logic        sec_req_n,        // REQ_L of secondary master
  output var  logic        lock_long_req_en  // Long lock request mode
);

  ////////////////////////////////////////////////////////////////////////////
  // State: index 0 of the master vectors is primary, 1 is secondary
  typedef struct packed {
    logic [7:0]  flags;     // Sticky cause flags
    logic [15:0] opt;       // Port option register
    logic [31:0] rdata;     // Read data holding register
    logic        serr_n;    // System-error output, low active
    logic [1:0]  req_n;     // Request outputs, low active
    logic [1:0]  dropped;   // Request released for this tenure
    logic        long_lock; // Copy of the long lock option
  } bsc_state_t;

  bsc_state_t q;      // Current state
  bsc_state_t next_q; // Next state

  ////////////////////////////////////////////////////////////////////////////
  // Decodes shared by the update logic and the checks
  logic [7:0]  set_vec;  // Causes that actually drive the output
  logic        wr_stat;  // Write to the cause flag register
  logic        wr_opt;   // Write to the port option register
  logic [7:0]  clr_vec;  // Ones written to the flag field
  logic [15:0] opt_wm;   // Writable option bits under byte enables
  logic [1:0]  hold;     // Master keeps its request through FRAME_L
  logic [1:0]  pending;  // Per-master FIFO pending
  logic [1:0]  frame;    // Per-master FRAME_L driven
  logic [1:0]  term;     // Per-master target termination
  logic [1:0]  lock;     // Per-master lock cycle

  assign pending = {sec_pending, pri_pending};
  assign frame   = {sec_frame, pri_frame};
  assign term    = {sec_target_term, pri_target_term};
  assign lock    = {sec_lock, pri_lock};

  // A cause counts only when its disable is clear and enable is set
  assign set_vec = serr_event & ~serr_disable & {8{serr_enable}};

  // Register hits
  assign wr_stat = cfg_wr && cfg_addr == bsc_pkg::SERR_STATUS_OFS &&
                   cfg_be[bsc_pkg::STAT_LANE];
  assign wr_opt  = cfg_wr && cfg_addr == bsc_pkg::PORT_OPT_OFS;

  // Only ones clear; zeros in the data leave the flags alone
  assign clr_vec = wr_stat ? cfg_wdata[bsc_pkg::STAT_LSB +: bsc_pkg::STAT_W]
                           : bsc_pkg::STAT_RESET;

  // Reserved bits fall outside the mask and never change
  assign opt_wm = wr_opt ? (bsc_pkg::OPT_WMASK & {{8{cfg_be[1]}}, {8{cfg_be[0]}}})
                         : 16'h0000;

  // Hold option, or a lock cycle under the long lock option
  assign hold[0] = q.opt[bsc_pkg::OPT_PRI_HOLD] ||
                   (lock[0] && q.opt[bsc_pkg::OPT_LONG_LOCK]);
  assign hold[1] = q.opt[bsc_pkg::OPT_SEC_HOLD] ||
                   (lock[1] && q.opt[bsc_pkg::OPT_LONG_LOCK]);

  ////////////////////////////////////////////////////////////////////////////
  // Next state
  always_comb begin
    next_q = q;

    // Set beats clear, so an event in the clearing cycle survives
    next_q.flags = (q.flags & ~clr_vec) | set_vec;

    // Output goes low for one cycle after each cycle with a qualifying cause
    next_q.serr_n = ~|set_vec;

    // Port option write, masked by writable bits
    next_q.opt = (q.opt & ~opt_wm) | (cfg_wdata[bsc_pkg::OPT_W-1:0] & opt_wm);

    // Long lock mode is exported for the arbiter side
    next_q.long_lock = q.opt[bsc_pkg::OPT_LONG_LOCK];

    // Read data is latched on the strobe and held until the next read
    if (cfg_rd) begin
      case (cfg_addr)
        bsc_pkg::SERR_STATUS_OFS: begin
          next_q.rdata = 32'h0000_0000;
          next_q.rdata[bsc_pkg::STAT_LSB +: bsc_pkg::STAT_W] = q.flags;
        end
        bsc_pkg::PORT_OPT_OFS: begin
          next_q.rdata = {16'h0000, q.opt};
        end
        default: begin
          next_q.rdata = 32'h0000_0000; // Unowned offsets read zero
        end
      endcase
    end

    // Request per master; a released request returns once the
    // transaction ends and the FIFO still has work
    for (int i = 0; i < 2; i++) begin
      if (!pending[i]) begin
        // Nothing pending: request withdrawn
        next_q.dropped[i] = 1'b0;
      end else if (q.dropped[i]) begin
        // Stay released while this tenure is still running
        next_q.dropped[i] = frame[i] || term[i];
      end else begin
        // Release on FRAME_L unless holding, always on termination
        next_q.dropped[i] = !q.req_n[i] &&
                            ((frame[i] && !hold[i]) || term[i]);
      end
      next_q.req_n[i] = !(pending[i] && !next_q.dropped[i]);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Register the state
  always_ff @(posedge clk) begin
    if (rst) begin
      q         <= '0;
      q.flags   <= bsc_pkg::STAT_RESET;
      q.opt     <= bsc_pkg::OPT_RESET;
      q.serr_n  <= 1'b1;
      q.req_n   <= 2'b11;
    end else begin
      q <= next_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Retry matchers, one per port, each with its own alias options
  bsc_match_if pri_m ();
  bsc_match_if sec_m ();

  assign pri_m.queued_cmd = pri_queued_cmd;
  assign pri_m.retry_cmd  = pri_retry_cmd;
  assign pri_m.rd_alias   = q.opt[bsc_pkg::OPT_PRI_RD_ALIAS];
  assign pri_m.wr_alias   = q.opt[bsc_pkg::OPT_PRI_WR_ALIAS];
  assign sec_m.queued_cmd = sec_queued_cmd;
  assign sec_m.retry_cmd  = sec_retry_cmd;
  assign sec_m.rd_alias   = q.opt[bsc_pkg::OPT_SEC_RD_ALIAS];
  assign sec_m.wr_alias   = q.opt[bsc_pkg::OPT_SEC_WR_ALIAS];

  // Primary port matcher
  bsc_cmd_match u_pri_match (
    .clk (clk),
    .rst (rst),
    .m   (pri_m.matcher)
  );

  // Secondary port matcher
  bsc_cmd_match u_sec_match (
    .clk (clk),
    .rst (rst),
    .m   (sec_m.matcher)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Outputs, all straight from flip-flops
  assign cfg_rdata                  = q.rdata;
  assign primary_system_error_out_n = q.serr_n;
  assign pri_req_n                  = q.req_n[0];
  assign sec_req_n                  = q.req_n[1];
  assign lock_long_req_en           = q.long_lock;
  assign pri_cmd_match              = pri_m.match;
  assign sec_cmd_match              = sec_m.match;

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  a_addr_par_set: assert property (
    set_vec[bsc_pkg::CAUSE_ADDR_PAR] |=> q.flags[bsc_pkg::CAUSE_ADDR_PAR] && !q.serr_n)
    else $error("address parity flag not set with output");

  a_pw_par_sticky: assert property (
    set_vec[bsc_pkg::CAUSE_PW_PAR] ##1 !wr_stat [*3] |=> q.flags[bsc_pkg::CAUSE_PW_PAR])
    else $error("posted parity flag lost without clear");

  a_pw_retry_set: assert property (
    set_vec[bsc_pkg::CAUSE_PW_RETRY] && wr_stat |=> q.flags[bsc_pkg::CAUSE_PW_RETRY])
    else $error("posted retry flag lost to clear");

  a_causes_set: assert property (
    set_vec != 8'h00 |=> (q.flags & $past(set_vec)) == $past(set_vec))
    else $error("cause flag not set");

  a_wc_clears: assert property (
    wr_stat && !set_vec[bsc_pkg::CAUSE_DT_TMO] &&
    cfg_wdata[bsc_pkg::STAT_LSB + bsc_pkg::CAUSE_DT_TMO]
    |=> !q.flags[bsc_pkg::CAUSE_DT_TMO])
    else $error("write one did not clear flag");

  a_zero_keeps: assert property (
    wr_stat && q.flags[bsc_pkg::CAUSE_DR_NODATA] &&
    !cfg_wdata[bsc_pkg::STAT_LSB + bsc_pkg::CAUSE_DR_NODATA]
    |=> q.flags[bsc_pkg::CAUSE_DR_NODATA])
    else $error("write zero changed flag");

  a_set_needs_serr: assert property (
    $rose(q.flags[bsc_pkg::CAUSE_DW_RETRY]) |-> !q.serr_n)
    else $error("flag set without system error");

  a_disable_mutes: assert property (
    (!serr_enable || serr_disable == 8'hFF) |=> q.serr_n)
    else $error("system error asserted while disabled");

  a_reserved_zero: assert property (
    (q.opt & ~bsc_pkg::OPT_WMASK) == 16'h0000)
    else $error("reserved option bit nonzero");

  a_sec_release: assert property (
    !q.req_n[1] && sec_pending && sec_frame && !hold[1] |=> q.req_n[1] ##1
    (q.req_n[1] || !$past(sec_frame) && !$past(sec_target_term)))
    else $error("secondary request not released on frame");

  a_sec_hold: assert property (
    !q.req_n[1] && sec_pending && hold[1] && !sec_target_term |=> !q.req_n[1])
    else $error("secondary request dropped while holding");

  a_pri_release: assert property (
    !q.req_n[0] && pri_pending && pri_frame && !hold[0] |=> q.req_n[0])
    else $error("primary request not released on frame");

  a_pri_hold: assert property (
    !q.req_n[0] && pri_pending && hold[0] && !pri_target_term |=> !q.req_n[0])
    else $error("primary request dropped while holding");

  a_term_release: assert property (
    !q.req_n[0] && pri_target_term |=> q.req_n[0])
    else $error("primary request kept after termination");

  a_lock_mode_out: assert property (
    q.long_lock == $past(q.opt[bsc_pkg::OPT_LONG_LOCK]))
    else $error("long lock output not following option");

  a_opt_unwritten: assert property (
    !wr_opt |=> $stable(q.opt))
    else $error("port options changed without a write");

  a_serr_follows: assert property (
    set_vec != 8'h00 |=> !q.serr_n)
    else $error("qualified cause did not assert system error");

  a_flags_need_cause: assert property (
    set_vec == 8'h00 |=> (q.flags & ~$past(q.flags)) == 8'h00)
    else $error("flag set without a qualified cause");

endmodule : bsc_regs

`default_nettype wire

// *** test/bsc_bus_model.sv ***
// Arbiter and target seen by one internal master of the bridge.
// Assumes an active-low registered request and one clock, clk.
`timescale 1ns/10ps
`default_nettype none

module bsc_bus_model (
  input  wire logic clk,     // PCI clock
  input  wire logic rst,     // Synchronous reset, high
  input  wire logic req_n,   // Master request, active low
  input  wire logic term_en, // Target ends the burst
  output var  logic frame,   // Master drives FRAME_L
  output var  logic term     // Target termination pulse
);
  logic [2:0] cnt; // Grant delay, then burst position

  ////////////////////////////////////////////////////////////////////////
  // Grant two cycles into a request, burst of three cycles; a slow grant
  // shows whether the master holds or drops its request meanwhile
  always_ff @(posedge clk) begin
    term <= 1'b0;
    if (rst) begin
      cnt   <= 3'h0;
      frame <= 1'b0;
    end else if (frame) begin
      cnt  <= cnt + 3'h1;
      term <= term_en && cnt == 3'h3; // Ends with the last data cycle
      if (cnt == 3'h4) begin
        frame <= 1'b0;
        cnt   <= 3'h0;
      end
    end else if (!req_n) begin
      cnt   <= cnt + 3'h1;
      frame <= cnt == 3'h1;
    end else begin
      cnt   <= 3'h0; // Withdrawn request restarts the grant delay
    end
  end
endmodule : bsc_bus_model

`default_nettype wire

// *** test/bridge_serr_cause_and_port_options_tb.sv ***
// Self-checking bench for the cause flags, port options and request hold.
// Assumes bsc_regs as top and one bus model per internal master.
`timescale 1ns/10ps
`default_nettype none

module bridge_serr_cause_and_port_options_tb;
  logic        clk = 0, rst = 1, cfg_rd = 0, cfg_wr = 0;   // Clock, strobes
  logic [7:0]  cfg_addr = 0, serr_disable = 0, serr_event = 0; // Address, causes
  logic [3:0]  cfg_be = 0, pri_queued_cmd = 0, pri_retry_cmd = 0; // Lanes, commands
  logic [3:0]  sec_queued_cmd = 0, sec_retry_cmd = 0;      // Secondary commands
  logic [31:0] cfg_wdata = 0, cfg_rdata, exp;              // Data, expectation
  logic        serr_enable = 0, serr_n, pri_cmd_match, sec_cmd_match, lock_en;
  logic        pri_pending = 0, pri_frame, pri_term, pri_lock = 0, pri_req_n;
  logic        sec_pending = 0, sec_frame, sec_term, sec_lock = 0, sec_req_n;
  logic        term_en = 0, e;                             // Target ends, expect
  logic [1:0]  al;                                         // Alias enables
  logic [3:0]  q, r;                                       // Table commands
  int          error_cnt = 0, n_compared = 0, cyc = 0, w;  // Counters
  // Retry table: {wr alias, rd alias, queued, retried, match}
  logic [10:0] mt [7] = '{{2'b01, 4'h6, 4'hC, 1'b1}, {2'b01, 4'h6, 4'hE, 1'b1},
                          {2'b00, 4'h6, 4'hC, 1'b0}, {2'b10, 4'h7, 4'hF, 1'b1},
                          {2'b00, 4'h7, 4'hF, 1'b0}, {2'b01, 4'h7, 4'hF, 1'b0},
                          {2'b00, 4'h7, 4'h7, 1'b1}};

  always #2.5 clk = ~clk; // 200 MHz

  bsc_regs bsc_regs_i (.clk(clk), .rst(rst), .cfg_rd(cfg_rd), .cfg_wr(cfg_wr),
    .cfg_addr(cfg_addr), .cfg_be(cfg_be), .cfg_wdata(cfg_wdata), .cfg_rdata(cfg_rdata),
    .serr_enable(serr_enable), .serr_disable(serr_disable), .serr_event(serr_event),
    .primary_system_error_out_n(serr_n), .pri_queued_cmd(pri_queued_cmd),
    .pri_retry_cmd(pri_retry_cmd), .pri_cmd_match(pri_cmd_match),
    .sec_queued_cmd(sec_queued_cmd), .sec_retry_cmd(sec_retry_cmd),
    .sec_cmd_match(sec_cmd_match), .pri_pending(pri_pending), .pri_frame(pri_frame),
    .pri_target_term(pri_term), .pri_lock(pri_lock), .pri_req_n(pri_req_n),
    .sec_pending(sec_pending), .sec_frame(sec_frame), .sec_target_term(sec_term),
    .sec_lock(sec_lock), .sec_req_n(sec_req_n), .lock_long_req_en(lock_en));
  bsc_bus_model pri_bus (.clk(clk), .rst(rst), .req_n(pri_req_n), .term_en(term_en),
    .frame(pri_frame), .term(pri_term));
  bsc_bus_model sec_bus (.clk(clk), .rst(rst), .req_n(sec_req_n), .term_en(term_en),
    .frame(sec_frame), .term(sec_term));

  ////////////////////////////////////////////////////////////////////////
  // Drive just after each rising edge
  task automatic tick;
    @(posedge clk);
    #1;
  endtask : tick

  task automatic chk(input logic [31:0] got, input logic [31:0] want);
    n_compared++;
    if (got !== want) begin
      error_cnt++;
      $display("mismatch at %0t: got %h expected %h", $time, got, want);
    end
  endtask : chk

  // Idle cycle after each access keeps strobes from toggling twice
  task automatic wr(input logic [7:0] a, input logic [3:0] be, input logic [31:0] d);
    cfg_wr = 1'b1;
    cfg_addr = a;
    cfg_be = be;
    cfg_wdata = d;
    tick;
    cfg_wr = 1'b0;
    tick;
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [31:0] want);
    cfg_rd = 1'b1;
    cfg_addr = a;
    tick;
    cfg_rd = 1'b0;
    chk(cfg_rdata, want);
    tick;
  endtask : rd

  task automatic test_done;
    $display("compared %0d, mismatches %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : test_done

  // Run takes under two hundred cycles; ceiling leaves ample margin
  always @(posedge clk) begin
    cyc++;
    if (cyc == 3000) begin
      error_cnt++;
      test_done;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (3) tick;
    rst = 1'b0;
    tick;
    rd(8'h68, 32'h0);
    rd(8'h74, 32'h0C00);
    rd(8'h70, 32'h0); // Unmapped place reads zero
    chk({31'h0, lock_en}, 32'h0);
    wr(8'h74, 4'h3, 32'hFFFFFFFF);
    rd(8'h74, 32'h0E1E);
    chk({31'h0, lock_en}, 32'h1);
    $display("test options done");
    // Each cause pulses the output once and sets its own flag
    serr_enable = 1'b1;
    exp = 32'h0;
    for (int i = 0; i < 8; i++) begin
      serr_event = 8'h01 << i;
      tick;
      serr_event = 8'h00;
      chk({31'h0, serr_n}, 32'h0);
      tick;
      chk({31'h0, serr_n}, 32'h1);
      exp[16 + i] = 1'b1;
      rd(8'h68, exp);
    end
    wr(8'h68, 4'hB, 32'hFFFFFFFF);
    rd(8'h68, exp);
    wr(8'h68, 4'hF, 32'h0);
    rd(8'h68, exp);
    wr(8'h68, 4'h4, 32'h00AA0000);
    rd(8'h68, 32'h00550000);
    wr(8'h68, 4'h4, 32'h00550000);
    rd(8'h68, 32'h0);
    // Cause held through the clearing write and the idle cycle after it: flag reads set
    serr_event = 8'h04;
    wr(8'h68, 4'h4, 32'h00040000);
    serr_event = 8'h00;
    rd(8'h68, 32'h00040000);
    wr(8'h68, 4'h4, 32'h00FF0000);
    rd(8'h68, 32'h0);
    // Masked causes, then the enable low: no output, no flag
    for (int m = 0; m < 2; m++) begin
      serr_disable = m == 0 ? 8'hFF : 8'h00;
      serr_enable = m == 1 ? 1'b0 : 1'b1;
      serr_event = 8'hFF;
      tick;
      serr_event = 8'h00;
      chk({31'h0, serr_n}, 32'h1);
      rd(8'h68, 32'h0);
    end
    $display("test causes done");
    // Retry matching, same commands on both ports
    foreach (mt[k]) begin
      {al, q, r, e} = mt[k];
      wr(8'h74, 4'h3, {27'h0, al, al, 1'b0});
      pri_queued_cmd = q;
      pri_retry_cmd = r;
      sec_queued_cmd = q;
      sec_retry_cmd = r;
      tick;
      chk({pri_cmd_match, sec_cmd_match}, {e, e});
    end
    // One port's alias bits at a time: the other port stays exact
    pri_queued_cmd = 4'h6;
    pri_retry_cmd = 4'hE;
    sec_queued_cmd = 4'h6;
    sec_retry_cmd = 4'hE;
    for (int p = 0; p < 2; p++) begin
      wr(8'h74, 4'h3, p == 0 ? 32'h0000_0002 : 32'h0000_0008);
      chk({pri_cmd_match, sec_cmd_match}, p == 0 ? 2'b10 : 2'b01);
    end
    $display("test matching done");
    // Release, hold, hold for lock only, primary hold only; then empty FIFO
    for (int m = 0; m < 4; m++) begin
      wr(8'h74, 4'h3, m == 0 ? 32'h0 : m == 1 ? 32'h0C00 : m == 2 ? 32'h0200 : 32'h0800);
      pri_lock = m == 2;
      sec_lock = m == 2;
      pri_pending = 1'b1;
      sec_pending = 1'b1;
      for (w = 0; w < 20 && pri_frame !== 1'b1; w++) tick;
      tick;
      exp = m == 0 ? 32'h3 : m == 3 ? 32'h1 : 32'h0;
      chk({pri_req_n, sec_req_n}, exp);
      pri_pending = 1'b0;
      sec_pending = 1'b0;
      tick;
      tick;
      chk({pri_req_n, sec_req_n}, 2'b11);
      for (w = 0; w < 20 && pri_frame !== 1'b0; w++) tick;
      tick;
    end
    // Held request ends on target termination
    wr(8'h74, 4'h3, 32'h0C00);
    term_en = 1'b1;
    pri_lock = 1'b0;
    sec_lock = 1'b0;
    pri_pending = 1'b1;
    sec_pending = 1'b1;
    for (w = 0; w < 30 && pri_term !== 1'b1; w++) tick;
    tick;
    chk({pri_req_n, sec_req_n}, 2'b11);
    $display("test requests done");
    test_done;
  end
endmodule : bridge_serr_cause_and_port_options_tb

`default_nettype wire
